// File: core/ubd_regs.sv
// How it works
// - Twelve-bit divisor: high nibble, low byte.
// - High byte and frame control share location.
// - High byte reads select bit as zero.
// - Low byte write reloads prescaler immediately.
// - Divisor zero ticks every clock.
// - Double speed halves bit period sixteen-to-eight, async mode only.
// - Select one targets frame control, reads one.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ubd_consts.svh"

module ubd_regs
#(
    parameter int DIV_W = 12
)
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Rate outputs to transmitter and receiver
    output logic rate_tick,
    output logic bit_tick,
    output logic double_speed_bit,
    output logic [7:0] frame_control_reg
);
    // Divisor and control state
    logic [DIV_W-1:0] rate_divisor;
    logic [DIV_W-1:0] next_rate_divisor;
    logic [7:0] next_frame_control_reg;
    logic next_double_speed_bit;
    logic sync_mode;
    logic next_sync_mode;
    logic load;
    logic next_load;

    // Write channel state
    logic aw_held;
    logic next_aw_held;
    logic [3:0] aw_addr;
    logic [3:0] next_aw_addr;
    logic w_held;
    logic next_w_held;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic wr_go;

    // Read channel state
    ubd_pkg::ubd_state_t rd_state;
    ubd_pkg::ubd_state_t next_rd_state;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // Prescaler tick and bit-period counter
    logic pre_tick;
    logic [4:0] sample_count;
    logic [4:0] next_sample_count;
    logic next_bit_tick;
    logic [4:0] ovs;

    // Write side: catch address and data in either order, then commit
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rate_divisor = rate_divisor;
        next_frame_control_reg = frame_control_reg;
        next_double_speed_bit = double_speed_bit;
        next_sync_mode = sync_mode;
        next_load = 1'b0;
        wr_go = aw_held && w_held && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_go)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `UBD_RESP_OKAY;
            case (aw_addr)
                `UBD_ADDR_SHARED:
                begin
                    if (w_data[`UBD_SEL_BIT] == 1'b0)
                    begin
                        // Divisor high nibble; reserved 14:12 ignored
                        if (w_strb[1])
                        begin
                            next_rate_divisor[DIV_W-1:8] = w_data[`UBD_HIGH_MSB:`UBD_HIGH_LSB];
                        end
                    end
                    else if (w_strb[0])
                    begin
                        next_frame_control_reg = w_data[7:0];
                        next_frame_control_reg[`UBD_CTRL_SEL_BIT] = 1'b1;
                    end
                end
                `UBD_ADDR_LOW:
                begin
                    if (w_strb[0])
                    begin
                        next_rate_divisor[7:0] = w_data[7:0];
                        next_load = 1'b1;
                    end
                end
                `UBD_ADDR_CTRL:
                begin
                    if (w_strb[0])
                    begin
                        next_double_speed_bit = w_data[`UBD_CTRL_DSPEED];
                        next_sync_mode = w_data[`UBD_CTRL_SYNC];
                    end
                end
                `UBD_ADDR_STATUS:
                begin
                    next_bresp = `UBD_RESP_OKAY; // Read-only, write ignored
                end
                default:
                begin
                    next_bresp = `UBD_RESP_SLVERR;
                end
            endcase
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        // Ready low while a word is held or a response waits, so a second write cannot overtake it
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
    end

    // Write side registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UBD_RESP_OKAY;
            rate_divisor <= `UBD_DIV_RESET;
            frame_control_reg <= `UBD_FRAME_RESET;
            double_speed_bit <= 1'b0;
            sync_mode <= 1'b0;
            load <= 1'b0;
        end
        else if (clk_en)
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            rate_divisor <= next_rate_divisor;
            frame_control_reg <= next_frame_control_reg;
            double_speed_bit <= next_double_speed_bit;
            sync_mode <= next_sync_mode;
            load <= next_load;
        end
    end

    // Read side: one read at a time, answer one cycle after the address
    always_comb
    begin
        next_rd_state = rd_state;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        case (rd_state)
            ubd_pkg::UBD_IDLE:
            begin
                next_arready = 1'b1;
                if (s_axi_arvalid && s_axi_arready)
                begin
                    next_arready = 1'b0;
                    next_rvalid = 1'b1;
                    next_rresp = `UBD_RESP_OKAY;
                    next_rdata = 32'h0000_0000;
                    next_rd_state = ubd_pkg::UBD_RESP;
                    case (s_axi_araddr)
                        `UBD_ADDR_SHARED:
                        begin
                            // Low byte: frame control, select reads one; bits 11:8: divisor
                            // high nibble, select bit 15 reads zero
                            next_rdata[7:0] = frame_control_reg;
                            next_rdata[`UBD_HIGH_MSB:`UBD_HIGH_LSB] = rate_divisor[DIV_W-1:8];
                            next_rdata[`UBD_SEL_BIT] = 1'b0;
                        end
                        `UBD_ADDR_LOW:
                        begin
                            next_rdata[7:0] = rate_divisor[7:0];
                        end
                        `UBD_ADDR_STATUS:
                        begin
                            next_rdata[4:0] = sample_count;
                        end
                        `UBD_ADDR_CTRL:
                        begin
                            next_rdata[`UBD_CTRL_DSPEED] = double_speed_bit;
                            next_rdata[`UBD_CTRL_SYNC] = sync_mode;
                        end
                        default:
                        begin
                            next_rresp = `UBD_RESP_SLVERR;
                        end
                    endcase
                end
            end
            ubd_pkg::UBD_RESP:
            begin
                if (s_axi_rready)
                begin
                    next_rvalid = 1'b0;
                    next_arready = 1'b1;
                    next_rd_state = ubd_pkg::UBD_IDLE;
                end
            end
            default:
            begin
                next_rd_state = ubd_pkg::UBD_IDLE;
            end
        endcase
    end

    // Read side registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state <= ubd_pkg::UBD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UBD_RESP_OKAY;
        end
        else if (clk_en)
        begin
            rd_state <= next_rd_state;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // Rate prescaler, reloaded on a low byte write
    ubd_prescaler #(.DIV_W(DIV_W)) u_prescaler
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .load(load),
        .divisor(rate_divisor),
        .tick(pre_tick)
    );

    // Bit period: sixteen ticks, eight in double speed (async only)
    always_comb
    begin
        ovs = (double_speed_bit && !sync_mode) ? `UBD_OVS_DOUBLE : `UBD_OVS_NORMAL;
        next_sample_count = sample_count;
        next_bit_tick = 1'b0;
        if (load)
        begin
            next_sample_count = 5'h00; // Restart the bit period with the new rate
        end
        else if (pre_tick)
        begin
            if (sample_count >= ovs - 5'h01)
            begin
                next_sample_count = 5'h00;
                next_bit_tick = 1'b1;
            end
            else
            begin
                next_sample_count = sample_count + 5'h01;
            end
        end
    end

    // Bit period registers; rate_tick is a registered copy of the prescaler tick
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sample_count <= 5'h00;
            bit_tick <= 1'b0;
            rate_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            sample_count <= next_sample_count;
            bit_tick <= next_bit_tick;
            rate_tick <= pre_tick;
        end
    end
endmodule
`default_nettype wire

// File: core/ubd_consts.svh
`ifndef UBD_CONSTS_SVH
`define UBD_CONSTS_SVH

// Register byte addresses on the AXI4-Lite bus
`define UBD_ADDR_SHARED 4'h0
`define UBD_ADDR_LOW 4'h4
`define UBD_ADDR_STATUS 4'h8
`define UBD_ADDR_CTRL 4'hc

// Field positions in the shared location word
`define UBD_SEL_BIT 15
`define UBD_HIGH_MSB 11
`define UBD_HIGH_LSB 8
`define UBD_CTRL_SEL_BIT 7
`define UBD_HIGH_FIELD_MSB 3

// Control register bits
`define UBD_CTRL_DSPEED 0
`define UBD_CTRL_SYNC 1

// Reset values
`define UBD_DIV_RESET 12'h000
`define UBD_FRAME_RESET 8'h86

// Samples per bit in normal and double-speed asynchronous mode
`define UBD_OVS_NORMAL 5'h10
`define UBD_OVS_DOUBLE 5'h08

// AXI responses
`define UBD_RESP_OKAY 2'h0
`define UBD_RESP_SLVERR 2'h2

`endif

// File: core/ubd_pkg.sv
package ubd_pkg;
    typedef enum logic [1:0]
    {
        UBD_IDLE = 2'b00,
        UBD_RESP = 2'b01
    } ubd_state_t;
endpackage

// File: core/ubd_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
`include "ubd_consts.svh"

module ubd_prescaler
#(
    parameter int DIV_W = 12
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Divisor load
    input wire logic load,
    input wire logic [DIV_W-1:0] divisor,
    // Rate tick out
    output logic tick
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic next_tick;

    // Count down from the divisor; tick and reload when the count reaches zero
    always_comb
    begin
        next_count = count;
        next_tick = 1'b0;
        if (load)
        begin
            next_count = divisor;
        end
        else if (count == '0)
        begin
            next_count = divisor;
            next_tick = 1'b1;
        end
        else
        begin
            next_count = count - 1'b1;
        end
    end

    // Registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= `UBD_DIV_RESET;
            tick <= 1'b0;
        end
        else if (clk_en)
        begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

// File: verification/ubd_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ubd_regs_chk
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Rate side
    input wire logic bit_tick,
    input wire logic double_speed_bit,
    input wire logic [7:0] frame_control_reg
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Both write halves taken at one edge, as the bench offers them
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    wr_lat_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid) else $error("write response late");
    rd_lat_a: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
    frame_sel_a: assert property (frame_control_reg[7]) else $error("frame select bit low");
    bit_pulse_a: assert property (bit_tick |=> !bit_tick) else $error("bit tick too wide");
    // Reset values hold even with the default disable overridden
    reset_val_a: assert property (disable iff (1'b0) !aresetn |=> frame_control_reg == 8'h86 && !double_speed_bit)
        else $error("reset value wrong");
endmodule
`default_nettype wire

// File: verification/ubd_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module ubd_regs_tb_top;
    // Bench drive, all valued at time zero
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rate_tick, bit_tick, double_speed_bit;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] frame_control_reg;
    logic clk_en = 1'b1;
    logic [1:0] exp_resp = 2'h0;
    int failures = 0;
    int n_tests = 0;
    int f, n;

    // Design under test; the bench owns the clock enable so freezing can be exercised
    ubd_regs ubd_regs_i (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rate_tick, .bit_tick, .double_speed_bit, .frame_control_reg);

    initial
    begin
        forever #25 aclk = ~aclk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tmo();
        failures++;
        $display("[ERR] wait expected answer seen timeout");
        print_verdict();
    endtask

    // Write: address and data offered together, each released once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        if (i == 50)
            tmo();
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, exp_resp}, {30'h0, s_axi_bresp});
    endtask

    // Read one word and compare it
    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        if (i == 50)
            tmo();
        s_axi_rready <= 1'b0;
        chk({nm, " rresp"}, {30'h0, exp_resp}, {30'h0, s_axi_rresp});
        chk(nm, e, s_axi_rdata);
    endtask

    // Edges to the first tick, then edges between it and the next
    task automatic gap(input bit bt, output int fi, output int ni);
        int i;
        for (fi = 1; fi < 9000; fi++)
        begin
            @(posedge aclk);
            if (bt ? bit_tick : rate_tick)
                break;
        end
        if (fi == 9000)
            tmo();
        ni = 0;
        for (i = 0; i < 9000; i++)
        begin
            @(posedge aclk);
            ni++;
            if (bt ? bit_tick : rate_tick)
                break;
        end
        if (i == 9000)
            tmo();
    endtask

    task automatic t_reset();
        rdc("shared reset", 4'h0, 32'h86);
        rdc("low reset", 4'h4, 32'h0);
        chk("frame port", 32'h86, {24'h0, frame_control_reg});
        $display("test reset done");
    endtask

    // High write keeps select and reserved bits at zero; they must read back zero
    task automatic t_shared();
        wr(4'h0, 32'h0a00);
        rdc("high nibble", 4'h0, 32'h0a86);
        wr(4'h0, 32'h8005);
        rdc("frame write", 4'h0, 32'h0a85);
        chk("frame port", 32'h85, {24'h0, frame_control_reg});
        $display("test shared done");
    endtask

    // No frame is in flight on this bench, so the rate may change here
    task automatic t_divisor();
        wr(4'h4, 32'h03);
        gap(1'b0, f, n);
        chk("rate gap a03", 32'd2564, n);
        rdc("low readback", 4'h4, 32'h03);
        $display("test divisor done");
    endtask

    // A long count in flight must be cut short by the low write
    task automatic t_reload();
        wr(4'h0, 32'h0000);
        wr(4'h4, 32'h02);
        gap(1'b0, f, n);
        chk("reload soon", 32'h1, {31'h0, f <= 8});
        chk("rate gap 2", 32'd3, n);
        $display("test reload done");
    endtask

    task automatic t_zero();
        wr(4'h4, 32'h00);
        gap(1'b0, f, n);
        chk("rate gap 0", 32'd1, n);
        gap(1'b1, f, n);
        chk("bit gap normal", 32'd16, n);
        $display("test zero done");
    endtask

    task automatic t_speed();
        wr(4'hc, 32'h1);
        chk("double port", 32'h1, {31'h0, double_speed_bit});
        gap(1'b1, f, n);
        chk("bit gap double", 32'd8, n);
        wr(4'hc, 32'h3);
        gap(1'b1, f, n);
        chk("bit gap sync", 32'd16, n);
        wr(4'hc, 32'h0);
        $display("test speed done");
    endtask

    // Unmapped word: error answer, and no register is touched
    task automatic t_map();
        exp_resp = 2'h2;
        wr(4'h2, 32'hffff_ffff);
        rdc("unmapped", 4'h2, 32'h0);
        exp_resp = 2'h0;
        rdc("shared after", 4'h0, 32'h0085);
        $display("test map done");
    endtask

    // Enable low freezes the bit period, so the next tick slips by the frozen cycles
    task automatic t_freeze();
        gap(1'b1, f, n);
        clk_en <= 1'b0;
        repeat (10) @(posedge aclk);
        clk_en <= 1'b1;
        gap(1'b1, f, n);
        chk("frozen tick", 32'd16, f);
        chk("bit gap after", 32'd16, n);
        $display("test freeze done");
    endtask

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_shared();
        t_divisor();
        t_reload();
        t_zero();
        t_speed();
        t_map();
        t_freeze();
        print_verdict();
    end
endmodule

bind ubd_regs ubd_regs_chk ubd_regs_chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .bit_tick, .double_speed_bit, .frame_control_reg);
`default_nettype wire
